// file: core/seq_pkg.sv
// seq_pkg: constants and types of the line scan trigger sequencer
// assumes: one 20 MHz camera clock, registers reached over apb
package seq_pkg;
  // ==========================================================
  // timing
  localparam int CLK_NS = 50;
  localparam int EXPOSE_NS = 2000;
  localparam int READOUT_NS = 3000;
  localparam int EXPOSE_CYC = (EXPOSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READOUT_CYC = (READOUT_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_LINES = 8'h08;
  localparam logic [7:0] OFF_FRAMES = 8'h0c;
  localparam logic [7:0] OFF_PERIOD = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_COUNT = 8'h18;
  // ==========================================================
  // field positions and reset values
  localparam int CTRL_ACQ_ON = 0;
  localparam int CTRL_FRM_ON = 1;
  localparam int CTRL_LINE_ON = 2;
  localparam int CTRL_FRM_LEVEL = 3;
  localparam int CTRL_PART_CLOSE = 4;
  localparam int CTRL_CONT = 5;
  localparam int CTRL_RATE_EN = 6;
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] LINES_RST = 16'h0003;
  localparam logic [15:0] FRAMES_RST = 16'h0001;
  localparam logic [15:0] PERIOD_RST = 16'h0190;
  // ==========================================================
  // trigger channels
  localparam int TRG_N = 3;
  localparam int TRG_ACQ = 0;
  localparam int TRG_FRM = 1;
  localparam int TRG_LINE = 2;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_WACQ = 6'h02, S_WFRM = 6'h04,
    S_WLINE = 6'h08, S_EXP = 6'h10, S_RD = 6'h20
  } state_type;
endpackage

// file: core/trig_if.sv
// trig_if: conditioned trigger levels and edges
// assumes: driven by trig_cond, read by the sequencer core
`timescale 1ns/100ps
`default_nettype none
interface trig_if;
  logic [2:0] rise; // one-cycle pulse per synced rising edge
  logic [2:0] high; // synced level per channel
  modport cond (output rise, output high);
  modport seq (input rise, input high);
endinterface
`default_nettype wire

// file: core/trig_cond.sv
// trig_cond: synchronises the trigger pins and finds rising edges
// assumes: pins are asynchronous to clk_sys
`timescale 1ns/100ps
`default_nettype none
module trig_cond
  import seq_pkg::*;
(
  input wire logic clk_sys, // camera clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic [seq_pkg::TRG_N-1:0] pin, // raw trigger pins
  trig_if.cond tr // conditioned triggers
);
  typedef struct packed {
    logic [TRG_N-1:0] meta;
    logic [TRG_N-1:0] sync;
    logic [TRG_N-1:0] prev;
  } cond_type;
  cond_type r_reg;
  cond_type r_next;

  // ==========================================================
  // two flops, then one more for edge finding
  always_comb
  begin
    r_next = r_reg;
    r_next.meta = pin;
    r_next.sync = r_reg.meta;
    r_next.prev = r_reg.sync;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      r_reg <= '0;
    else if (ce)
      r_reg <= r_next;
  end

  // per channel outputs; meta is read by sync alone
  for (genvar i = 0; i < TRG_N; i++)
  begin : g_ch
    assign tr.high[i] = r_reg.sync[i];
    assign tr.rise[i] = r_reg.sync[i] & ~r_reg.prev[i];
  end
endmodule
`default_nettype wire

// file: core/line_timer.sv
// line_timer: paces internally started lines
// assumes: start pulses once per line start, same clock
`timescale 1ns/100ps
`default_nettype none
module line_timer (
  input wire logic clk_sys, // camera clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic start, // line starts now
  input wire logic rate_en, // pace by period
  input wire logic [15:0] period, // clocks from line to line
  output logic ready // next line may start
);
  typedef struct packed {
    logic [15:0] cnt;
  } tmr_type;
  tmr_type r_reg;
  tmr_type r_next;

  // ==========================================================
  // count down the rest of the line period
  always_comb
  begin
    r_next = r_reg;
    if (start)
      r_next.cnt = (period == 16'h0000) ? 16'h0000 : period - 16'h0001;
    else if (r_reg.cnt != 16'h0000)
      r_next.cnt = r_reg.cnt - 16'h0001;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      r_reg <= '0;
    else if (ce)
      r_reg <= r_next;
  end

  // with pacing off exposure plus readout sets the top rate
  assign ready = !rate_en || (r_reg.cnt == 16'h0000);
endmodule
`default_nettype wire

// file: core/line_scan_trigger_sequencer.sv
// line_scan_trigger_sequencer: acquisition, frame and line sequencing
// assumes: apb master on clk_sys, trigger pins asynchronous,
// frame results consumed by a transmit path without back-pressure
`timescale 1ns/100ps
`default_nettype none
module line_scan_trigger_sequencer
  import seq_pkg::*;
#(
  parameter int EXP_CYC = seq_pkg::EXPOSE_CYC,
  parameter int RD_CYC = seq_pkg::READOUT_CYC
)
(
  input wire logic clk_sys, // camera clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable, freezes all state
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // unmapped address
  input wire logic acq_trig_pin, // acquisition start trigger
  input wire logic frame_trig_pin, // frame start trigger
  input wire logic line_trig_pin, // line start trigger
  output logic exposing, // line exposure running
  output logic reading_out, // line readout running
  output logic line_done, // pulse: line read out
  output logic frame_done, // pulse: frame goes out
  output logic frame_partial, // frame sent short
  output logic [15:0] frame_lines, // lines in sent frame
  output logic wait_acq, // waiting for acquisition trigger
  output logic wait_frame, // waiting for frame trigger
  output logic wait_line // waiting for line trigger
);
  typedef struct packed {
    state_type st;
    logic [7:0] ctrl;
    logic [15:0] lines;
    logic [15:0] frames;
    logic [15:0] period;
    logic [15:0] cnt;
    logic [15:0] line_cnt;
    logic [15:0] frm_left;
    logic stop_pend;
    logic closing;
    logic line_done;
    logic frame_done;
    logic frame_partial;
    logic [15:0] frame_lines;
    logic [31:0] prdata;
  } seq_type;

  seq_type r_reg;
  seq_type r_next;
  trig_if tr ();
  logic tmr_ready, line_start, acc, wr, mapped;
  logic [31:0] rdata;
  logic start_wr, stop_wr, end_f, part_f, frame_go, line_go;
  logic acq_on, frm_on, line_on, frm_level, part_close, cont;

  // ==========================================================
  // submodules
  trig_cond u_cond (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .pin({line_trig_pin, frame_trig_pin, acq_trig_pin}),
    .tr(tr.cond)
  );

  line_timer u_tmr (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .start(line_start),
    .rate_en(r_reg.ctrl[CTRL_RATE_EN]),
    .period(r_reg.period),
    .ready(tmr_ready)
  );

  // ==========================================================
  // control fields
  assign acq_on = r_reg.ctrl[CTRL_ACQ_ON];
  assign frm_on = r_reg.ctrl[CTRL_FRM_ON];
  assign line_on = r_reg.ctrl[CTRL_LINE_ON];
  assign frm_level = r_reg.ctrl[CTRL_FRM_LEVEL];
  assign part_close = r_reg.ctrl[CTRL_PART_CLOSE];
  assign cont = r_reg.ctrl[CTRL_CONT];

  // ==========================================================
  // apb slave; ready follows ce so no access is lost while frozen
  assign pready = ce;
  assign acc = psel & penable & ce;
  assign wr = acc & pwrite & mapped;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = r_reg.prdata;
  assign start_wr = wr && (paddr == OFF_CMD) && pwdata[CMD_START];
  assign stop_wr = wr && (paddr == OFF_CMD) && pwdata[CMD_STOP];

  // read decode
  always_comb
  begin
    mapped = 1'b1;
    rdata = 32'h0000_0000;
    if (paddr == OFF_CTRL)
      rdata = {24'h00_0000, r_reg.ctrl};
    else if (paddr == OFF_CMD)
      rdata = 32'h0000_0000;
    else if (paddr == OFF_LINES)
      rdata = {16'h0000, r_reg.lines};
    else if (paddr == OFF_FRAMES)
      rdata = {16'h0000, r_reg.frames};
    else if (paddr == OFF_PERIOD)
      rdata = {16'h0000, r_reg.period};
    else if (paddr == OFF_STATUS)
      rdata = {21'h00_0000, wait_line, wait_frame, wait_acq,
               r_reg.closing, r_reg.stop_pend, r_reg.st};
    else if (paddr == OFF_COUNT)
      rdata = {r_reg.frm_left, r_reg.line_cnt};
    else
      mapped = 1'b0;
  end

  // ==========================================================
  // trigger qualification
  // an edge frame trigger only counts while waiting for it
  assign frame_go = !frm_on ||
    (frm_level ? tr.high[TRG_FRM] : tr.rise[TRG_FRM]);
  assign line_go = line_on ? tr.rise[TRG_LINE] : tmr_ready;
  assign line_start = (r_reg.st == S_WLINE) && line_go &&
    !r_reg.stop_pend && !r_reg.closing;

  // waits shown only for external triggers
  assign wait_acq = (r_reg.st == S_WACQ) && acq_on;
  assign wait_frame = (r_reg.st == S_WFRM) && frm_on;
  assign wait_line = (r_reg.st == S_WLINE) && line_on;
  assign exposing = (r_reg.st == S_EXP);
  assign reading_out = (r_reg.st == S_RD);
  assign line_done = r_reg.line_done;
  assign frame_done = r_reg.frame_done;
  assign frame_partial = r_reg.frame_partial;
  assign frame_lines = r_reg.frame_lines;

  // ==========================================================
  // next state
  always_comb
  begin
    r_next = r_reg;
    end_f = 1'b0;
    part_f = 1'b0;
    r_next.line_done = 1'b0;
    r_next.frame_done = 1'b0;
    if (psel)
      r_next.prdata = rdata;
    // register writes
    if (wr && paddr == OFF_CTRL)
      r_next.ctrl = pwdata[7:0];
    else if (wr && paddr == OFF_LINES)
      r_next.lines = pwdata[15:0];
    else if (wr && paddr == OFF_FRAMES)
      r_next.frames = pwdata[15:0];
    else if (wr && paddr == OFF_PERIOD)
      r_next.period = pwdata[15:0];
    // level dropped mid frame closes it early when allowed
    if ((r_reg.st == S_WLINE || r_reg.st == S_EXP || r_reg.st == S_RD)
        && frm_on && frm_level && part_close && !tr.high[TRG_FRM])
      r_next.closing = 1'b1;
    case (r_reg.st)
      S_IDLE:
      begin
        if (start_wr)
        begin
          r_next.st = S_WACQ;
          r_next.stop_pend = 1'b0;
        end
      end
      S_WACQ:
      begin
        if (r_reg.stop_pend)
          r_next.st = S_IDLE;
        else if (!acq_on || tr.rise[TRG_ACQ])
        begin
          r_next.st = S_WFRM;
          r_next.frm_left = r_reg.frames;
        end
      end
      S_WFRM:
      begin
        // line triggers fall through unused here
        if (r_reg.stop_pend)
          r_next.st = S_IDLE;
        else if (frame_go)
        begin
          r_next.st = S_WLINE;
          r_next.line_cnt = 16'h0000;
          r_next.closing = 1'b0;
        end
      end
      S_WLINE:
      begin
        if ((r_reg.stop_pend || r_reg.closing) &&
            r_reg.line_cnt == 16'h0000)
          r_next.st = r_reg.stop_pend ? S_IDLE : S_WFRM;
        else if (r_reg.stop_pend || r_reg.closing)
        begin
          end_f = 1'b1;
          part_f = 1'b1;
        end
        else if (line_go)
        begin
          r_next.st = S_EXP;
          r_next.cnt = 16'(EXP_CYC - 1);
        end
      end
      S_EXP:
      begin
        if (r_reg.stop_pend)
        begin
          end_f = 1'b1;
          part_f = 1'b1;
        end
        else if (r_reg.cnt == 16'h0000)
        begin
          r_next.st = S_RD;
          r_next.cnt = 16'(RD_CYC - 1);
        end
        else
          r_next.cnt = r_reg.cnt - 16'h0001;
      end
      S_RD:
      begin
        if (r_reg.cnt != 16'h0000)
          r_next.cnt = r_reg.cnt - 16'h0001;
        else
        begin
          // readout always completes, even under a stop
          r_next.line_cnt = r_reg.line_cnt + 16'h0001;
          r_next.line_done = 1'b1;
          if (r_next.line_cnt >= r_reg.lines)
            end_f = 1'b1;
          else if (r_reg.stop_pend)
          begin
            end_f = 1'b1;
            part_f = 1'b1;
          end
          else
            r_next.st = S_WLINE;
        end
      end
      default:
        r_next.st = S_IDLE;
    endcase
    // frame end bookkeeping
    if (end_f)
    begin
      r_next.frame_done = 1'b1;
      r_next.frame_partial = part_f;
      r_next.frame_lines = r_next.line_cnt;
      r_next.frm_left = r_reg.frm_left - 16'h0001;
      if (r_reg.stop_pend)
        r_next.st = S_IDLE;
      else if (r_reg.frm_left > 16'h0001)
        r_next.st = S_WFRM;
      else if (cont)
        r_next.st = S_WACQ;
      else
        r_next.st = S_IDLE;
    end
    if (r_next.st == S_IDLE)
      r_next.stop_pend = 1'b0;
    // a stop in the same cycle as the clear survives
    if (stop_wr && r_next.st != S_IDLE)
      r_next.stop_pend = 1'b1;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      r_reg <= '0;
      r_reg.st <= S_IDLE;
      r_reg.ctrl <= CTRL_RST;
      r_reg.lines <= LINES_RST;
      r_reg.frames <= FRAMES_RST;
      r_reg.period <= PERIOD_RST;
    end
    else if (ce)
      r_reg <= r_next;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst || !ce);

  acq_free_run_a: assert property (
    (r_reg.st == S_WACQ && !acq_on && !r_reg.stop_pend)
    |=> r_reg.st == S_WFRM)
    else $error("internal acquisition start not taken");
  line_free_run_a: assert property (
    (r_reg.st == S_WLINE && !line_on && tmr_ready &&
     !r_reg.stop_pend && !r_reg.closing)
    |=> r_reg.st == S_EXP ##(EXP_CYC)
        (r_reg.st == S_RD || r_reg.st == S_IDLE))
    else $error("internal line start not taken");
  level_frame_a: assert property (
    (r_reg.st == S_WFRM && frm_on && frm_level &&
     tr.high[TRG_FRM] && !r_reg.stop_pend)
    |=> r_reg.st == S_WLINE)
    else $error("level frame trigger did not start frame");
  edge_frame_a: assert property (
    (r_reg.st == S_WFRM && frm_on && !frm_level &&
     !tr.rise[TRG_FRM]) |=> r_reg.st != S_WLINE)
    else $error("frame started without edge");
  partial_close_a: assert property (
    (r_reg.st == S_WLINE && r_reg.closing && !r_reg.stop_pend &&
     r_reg.line_cnt != 16'h0000)
    |=> r_reg.frame_done && r_reg.frame_partial)
    else $error("closing frame not cut short");
  full_close_a: assert property (
    (!part_close && r_reg.st == S_WFRM) |=> !r_reg.closing)
    else $error("frame closed early without option");
  line_ignored_a: assert property (
    r_reg.st == S_WFRM |=> r_reg.st != S_EXP)
    else $error("line taken while waiting for frame");
  continuous_a: assert property (
    (r_reg.st != S_IDLE && cont && !r_reg.stop_pend && !stop_wr)
    |=> r_reg.st != S_IDLE)
    else $error("continuous acquisition stopped by itself");
  stop_idle_a: assert property (
    (r_reg.st == S_WLINE && r_reg.stop_pend &&
     r_reg.line_cnt != 16'h0000)
    |=> r_reg.frame_done && r_reg.frame_partial && r_reg.st == S_IDLE)
    else $error("partial frame lost on stop");
  stop_expose_a: assert property (
    (r_reg.st == S_EXP && r_reg.stop_pend)
    |=> r_reg.frame_done && !r_reg.line_done &&
        r_reg.frame_lines == $past(r_reg.line_cnt))
    else $error("exposing line not dropped on stop");
  stop_readout_a: assert property (
    (r_reg.st == S_RD && r_reg.cnt == 16'h0000 && r_reg.stop_pend)
    |=> r_reg.line_done && r_reg.frame_done &&
        r_reg.frame_lines == $past(r_reg.line_cnt) + 16'h0001)
    else $error("read out line not kept on stop");
  frame_count_a: assert property (
    (r_reg.st == S_WACQ ##1 r_reg.st == S_WFRM)
    |-> r_reg.frm_left == $past(r_reg.frames))
    else $error("frame count not loaded");
  acq_gate_a: assert property (
    (r_reg.st == S_WACQ && acq_on && !tr.rise[TRG_ACQ])
    |=> r_reg.st != S_WFRM)
    else $error("acquisition began without trigger");
  wait_flags_a: assert property (
    !((wait_acq && !acq_on) || (wait_frame && !frm_on) ||
      (wait_line && !line_on)))
    else $error("wait shown for internal trigger");
  full_frame_a: assert property (
    (r_reg.frame_done && !r_reg.frame_partial)
    |-> r_reg.frame_lines == r_reg.lines)
    else $error("full frame line count wrong");
  rearm_a: assert property (
    (r_reg.frame_done && !$past(r_reg.stop_pend) && cont &&
     r_reg.frm_left == 16'h0000) |-> r_reg.st == S_WACQ)
    else $error("no return to acquisition wait");
endmodule
`default_nettype wire

// file: tb/trig_model.sv
// trig_model: outside trigger sources and the frame transmit sink
// assumes: bench calls pulse and level between clock edges
`timescale 1ns/100ps
`default_nettype none
module trig_model (
  input wire logic clk_sys, // camera clock
  input wire logic frame_done, // frame handed to transmit
  output logic [2:0] pin, // acq, frame, line trigger pins
  output var int nfrm // frames taken by the sink
);
  // ==========================================================
  // sources: pins move only just after a rising edge
  initial pin = 3'h0;
  // held four edges so the two-flop sync cannot miss it
  task automatic pulse(input int ch);
    @(posedge clk_sys);
    pin[ch] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    pin[ch] <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  // level drive for level-high frame activation
  task automatic level(input int ch, input logic v);
    @(posedge clk_sys);
    pin[ch] <= v;
  endtask
  // ==========================================================
  // sink: takes every frame, no back-pressure
  initial nfrm = 0;
  always @(posedge clk_sys)
  begin
    if (frame_done === 1'b1)
      nfrm <= nfrm + 1;
  end
endmodule
`default_nettype wire

// file: tb/line_scan_trigger_sequencer_tb.sv
// line_scan_trigger_sequencer_tb: apb driven tests of the sequencer
// assumes: trig_model stands for trigger sources and transmit path
`timescale 1ns/100ps
`default_nettype none
module line_scan_trigger_sequencer_tb;
  import seq_pkg::*;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, e;
  logic ce;
  logic exposing, reading_out, line_done, frame_done, frame_partial;
  logic wait_acq, wait_frame, wait_line;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] frame_lines;
  logic [2:0] pin;
  logic [6:0] obs;
  logic [7:0] ra [4] = '{OFF_CTRL, OFF_LINES, OFF_FRAMES, OFF_PERIOD};
  logic [31:0] rv [4] = '{32'h0, 32'h3, 32'h1, 32'h190};
  int nfrm, err_total, checked, nline, nwa, nwf, nwl, b, b2, c2;
  assign obs = {wait_acq, wait_frame, wait_line, reading_out, exposing,
    frame_done, line_done};
  // ==========================================================
  // clock and instances; short exposure and readout keep runs brief
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  line_scan_trigger_sequencer #(.EXP_CYC(12), .RD_CYC(8))
    i_line_scan_trigger_sequencer (.clk_sys(clk_sys), .nrst(nrst),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .acq_trig_pin(pin[0]), .frame_trig_pin(pin[1]),
    .line_trig_pin(pin[2]), .exposing(exposing),
    .reading_out(reading_out), .line_done(line_done),
    .frame_done(frame_done), .frame_partial(frame_partial),
    .frame_lines(frame_lines), .wait_acq(wait_acq),
    .wait_frame(wait_frame), .wait_line(wait_line));
  trig_model i_trig_model (.clk_sys(clk_sys), .frame_done(frame_done),
    .pin(pin), .nfrm(nfrm));
  // running counts of lines and of wait indications
  always @(posedge clk_sys)
  begin
    nline <= nline + 32'(line_done === 1'b1);
    nwa <= nwa + 32'(wait_acq === 1'b1);
    nwf <= nwf + 32'(wait_frame === 1'b1);
    nwl <= nwl + 32'(wait_line === 1'b1);
  end
  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] ex,
    input logic [31:0] got);
    checked++;
    if (got !== ex)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // apb cycle; pready, read data and error taken at one rising edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // bounded wait for one observed output
  task automatic wt(input int s);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    while (obs[s] !== 1'b1 && n < 2000);
    if (n >= 2000)
      chk("wait", 32'h1, 32'h0);
  endtask
  task automatic frm(input logic [15:0] n, input logic p);
    wt(1);
    chk("frame_lines", {16'h0, n}, {16'h0, frame_lines});
    chk("frame_partial", {31'h0, p}, {31'h0, frame_partial});
  endtask
  // a line trigger only once the sequencer asks for it
  task automatic lines(input int n);
    repeat (n)
    begin
      wt(4);
      i_trig_model.pulse(TRG_LINE);
    end
  endtask
  task automatic halt;
    wr(OFF_CMD, 32'h2);
    repeat (60) @(posedge clk_sys);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // watchdog, far above the few thousand cycles the tests need
  initial
  begin
    #2000000;
    err_total++;
    report_and_stop;
  end
  // ==========================================================
  // tests
  initial
  begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    {err_total, checked, nline, nwa, nwf, nwl} = '0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      rd(ra[i]);
      chk("reset value", rv[i], q);
    end
    rd(8'h1c);
    chk("pslverr", 32'h1, {31'h0, e});
    $display("test registers done");
    // free run, single mode, two frames of two lines
    wr(OFF_LINES, 32'h2);
    wr(OFF_FRAMES, 32'h2);
    b = nwa + nwf + nwl;
    b2 = nfrm;
    wr(OFF_CMD, 32'h1);
    // freeze mid exposure: state must hold and pready must stay low while ce is low
    wt(2);
    @(posedge clk_sys);
    ce <= 1'b0;
    repeat (30) @(posedge clk_sys);
    chk("frozen", 32'h1, {31'h0, exposing});
    chk("pready", 32'h0, {31'h0, pready});
    ce <= 1'b1;
    frm(16'h2, 1'b0);
    frm(16'h2, 1'b0);
    repeat (100) @(posedge clk_sys);
    chk("frames", 32'(b2 + 2), 32'(nfrm));
    rd(OFF_STATUS);
    chk("state", 32'h1, {26'h0, q[5:0]});
    chk("waits", 32'(b), 32'(nwa + nwf + nwl));
    $display("test free run done");
    // external acquisition trigger, continuous
    wr(OFF_CTRL, 32'h21);
    b = nline;
    b2 = nwf + nwl;
    wr(OFF_CMD, 32'h1);
    repeat (60) @(posedge clk_sys);
    chk("early lines", 32'(b), 32'(nline));
    chk("wait_acq", 32'h1, {31'h0, wait_acq});
    i_trig_model.pulse(TRG_ACQ);
    frm(16'h2, 1'b0);
    frm(16'h2, 1'b0);
    wt(6);
    rd(OFF_STATUS);
    chk("state", 32'h2, {26'h0, q[5:0]});
    chk("waits", 32'(b2), 32'(nwf + nwl));
    halt;
    $display("test acq trigger done");
    // edge frame trigger with external lines
    wr(OFF_LINES, 32'h3);
    wr(OFF_FRAMES, 32'h1);
    wr(OFF_CTRL, 32'h26);
    wr(OFF_CMD, 32'h1);
    wt(5);
    b = nline;
    i_trig_model.pulse(TRG_LINE);
    i_trig_model.pulse(TRG_LINE);
    repeat (30) @(posedge clk_sys);
    chk("ignored lines", 32'(b), 32'(nline));
    i_trig_model.pulse(TRG_FRM);
    lines(3);
    frm(16'h3, 1'b0);
    wt(5);
    i_trig_model.pulse(TRG_LINE);
    repeat (30) @(posedge clk_sys);
    chk("paused", 32'(b + 3), 32'(nline));
    halt;
    $display("test edge frame done");
    // level frame trigger dropped during exposure
    for (int p = 1; p >= 0; p--)
    begin
      wr(OFF_CTRL, p ? 32'h3e : 32'h2e);
      i_trig_model.level(TRG_FRM, 1'b1);
      wr(OFF_CMD, 32'h1);
      lines(3);
      frm(16'h3, 1'b0);
      lines(1);
      wt(2);
      i_trig_model.level(TRG_FRM, 1'b0);
      if (p == 1)
        frm(16'h1, 1'b1);
      else
      begin
        lines(2);
        frm(16'h3, 1'b0);
      end
      halt;
    end
    $display("test level frame done");
    // continuous free run stopped in exposure, then in readout
    wr(OFF_CTRL, 32'h20);
    for (int s = 2; s <= 3; s++)
    begin
      wr(OFF_CMD, 32'h1);
      frm(16'h3, 1'b0);
      frm(16'h3, 1'b0);
      wt(0);
      wt(s);
      wr(OFF_CMD, 32'h2);
      frm(16'(s - 1), 1'b1);
      repeat (20) @(posedge clk_sys);
    end
    $display("test stop done");
    // line pacing on and off
    wr(OFF_PERIOD, 32'h28);
    for (int r = 1; r >= 0; r--)
    begin
      wr(OFF_CTRL, r ? 32'h60 : 32'h20);
      wr(OFF_CMD, 32'h1);
      wt(0);
      c2 = 0;
      do
      begin
        @(posedge clk_sys);
        #1;
        c2++;
      end
      while (line_done !== 1'b1 && c2 < 500);
      if (r == 1)
        chk("line period", 32'h28, 32'(c2));
      else
        chk("max rate", 32'h1, 32'(c2 < 40));
      halt;
    end
    $display("test pacing done");
    report_and_stop;
  end
endmodule
`default_nettype wire
